/* File: cnr_pkg.sv */
// Shared types and constants for the cell and nibble receive port
package cnr_pkg;
  // Receive mode: octet cells, nibbles, or single serial bit
  typedef enum logic [1:0] {
    CNR_MODE_CELL,
    CNR_MODE_NIBBLE,
    CNR_MODE_SERIAL
  } cnr_mode_t;

  localparam int unsigned CNR_CELL_OCTETS = 53;
  localparam int unsigned CNR_OCTET_W = 8;
  localparam int unsigned CNR_NIBBLE_W = 4;
  localparam logic [5:0] CNR_CNT_RST = 6'h00;
  localparam logic [7:0] CNR_DATA_RST = 8'h00;
  // Width codes carried with each handed-over unit
  localparam logic [2:0] CNR_WIDTH_OCTET = 3'h0;
  localparam logic [2:0] CNR_WIDTH_NIBBLE = 3'h4;
  localparam logic [2:0] CNR_WIDTH_BIT = 3'h1;

  // Word handed to the internal receive logic
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] width;
    logic       cell_start;
    logic       cell_end;
  } cnr_word_t;
endpackage

/* File: cnr_receive_port.sv */
// Receive port: octets, nibbles or serial bits from the link
// Overview of operation
// RQ1 - Cell mode takes whole octets on eight data lines, line 7 MSB.
// RQ2 - Cells are 53 octets; an octet counter tracks cell boundaries.
// RQ3 - PHY fills idle time with idle cells, keeping cell alignment.
// RQ4 - PHY drives data only while receive enable is asserted toward it; code asserts it in cell mode only, not for nibble or serial.
// RQ5 - Nibble modes take four bits on lines 0 to 3, line 3 MSB.
// RQ6 - Serial modes take data on a single serial input line.
// RQ7 - Data sampled on link clock edges, handed over synchronised.
`timescale 1ns/100ps
`default_nettype none
module cnr_receive_port (
  // System
  input wire logic sys_clk,
  input wire logic rst_b,
  // Configuration
  input wire cnr_pkg::cnr_mode_t mode,
  input wire logic port_enable,
  // Link pins
  input wire logic rx_clk,
  input wire logic [7:0] rx_data,
  input wire logic rx_serial,
  output logic receive_enable,
  // Internal receive side
  output cnr_pkg::cnr_word_t word,
  output logic word_valid
);
  logic [2:0] clk_sync_q;
  logic [7:0] data_s1_q, data_s2_q;
  logic ser_s1_q, ser_s2_q;
  logic [5:0] octet_cnt_q;
  cnr_pkg::cnr_word_t word_q;
  logic valid_q;
  logic rise;

  // Cell-mode test, shared by the enable, the counter and the checks
  function automatic logic is_cell(input cnr_pkg::cnr_mode_t m);
    return m == cnr_pkg::CNR_MODE_CELL;
  endfunction

  // Link clock and data: two flops before use
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clk_sync_q <= 3'h0;
      data_s1_q <= cnr_pkg::CNR_DATA_RST;
      data_s2_q <= cnr_pkg::CNR_DATA_RST;
      ser_s1_q <= 1'b0;
      ser_s2_q <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], rx_clk};
      data_s1_q <= rx_data;
      data_s2_q <= data_s1_q;
      ser_s1_q <= rx_serial;
      ser_s2_q <= ser_s1_q;
    end
  end

  // Edge seen only from synchronised copies
  assign rise = clk_sync_q[1] & ~clk_sync_q[2]; // RQ7

  // Enable toward the PHY, raised in cell mode only; there it drives the bus only while high
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      receive_enable <= 1'b0;
    end else begin
      receive_enable <= port_enable && is_cell(mode); // RQ4
    end
  end

  // Octet position within a cell; idle cells keep the count aligned
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !is_cell(mode) || !receive_enable) begin
      octet_cnt_q <= cnr_pkg::CNR_CNT_RST;
    end else if (rise) begin
      if (octet_cnt_q == 6'(cnr_pkg::CNR_CELL_OCTETS - 1)) begin // RQ2
        octet_cnt_q <= cnr_pkg::CNR_CNT_RST;
      end else begin
        octet_cnt_q <= octet_cnt_q + 6'h01;
      end
    end
  end

  // Capture one unit per link clock rising edge while port_enable is high; cell mode also needs receive_enable
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      word_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (rise && port_enable) begin
        valid_q <= 1'b1; // RQ7
        word_q.cell_start <= 1'b0;
        word_q.cell_end <= 1'b0;
        case (mode)
          cnr_pkg::CNR_MODE_CELL: begin
            if (receive_enable) begin
              word_q.data <= data_s2_q; // RQ1
              word_q.width <= cnr_pkg::CNR_WIDTH_OCTET;
              word_q.cell_start <= (octet_cnt_q == cnr_pkg::CNR_CNT_RST);
              word_q.cell_end <=
                (octet_cnt_q == 6'(cnr_pkg::CNR_CELL_OCTETS - 1)); // RQ2
            end else begin
              valid_q <= 1'b0;
            end
          end
          cnr_pkg::CNR_MODE_NIBBLE: begin
            word_q.data <= {4'h0, data_s2_q[3:0]}; // RQ5
            word_q.width <= cnr_pkg::CNR_WIDTH_NIBBLE;
          end
          cnr_pkg::CNR_MODE_SERIAL: begin
            word_q.data <= {7'h00, ser_s2_q}; // RQ6
            word_q.width <= cnr_pkg::CNR_WIDTH_BIT;
          end
          default: begin
            valid_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign word = word_q;
  assign word_valid = valid_q;

  a_cell_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    octet_cnt_q < 6'(cnr_pkg::CNR_CELL_OCTETS)) // RQ2
    else $error("Octet count out of range");

  a_end_marks: assert property (@(posedge sys_clk) disable iff (!rst_b)
    valid_q && word_q.cell_end |->
    $past(octet_cnt_q) == 6'(cnr_pkg::CNR_CELL_OCTETS - 1)) // RQ2
    else $error("Cell end at wrong octet");

  a_enable_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
    receive_enable |-> $past(mode) == cnr_pkg::CNR_MODE_CELL) // RQ4
    else $error("Enable outside cell mode");

  sequence s_edge;
    rise && port_enable;
  endsequence
  a_edge_valid: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_edge ##0 (mode != cnr_pkg::CNR_MODE_CELL) |=> valid_q) // RQ7
    else $error("Edge produced no word");

  a_no_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(rise) |-> !valid_q) // RQ7
    else $error("Word without link edge");

  a_octet_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_edge ##0 receive_enable ##0 (mode == cnr_pkg::CNR_MODE_CELL)
    |=> word_q.data == $past(data_s2_q)) // RQ1
    else $error("Octet data mismatch");

  a_nibble_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_edge ##0 (mode == cnr_pkg::CNR_MODE_NIBBLE)
    |=> word_q.data == {4'h0, $past(data_s2_q[3:0])}) // RQ5
    else $error("Nibble data mismatch");

  a_serial_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_edge ##0 (mode == cnr_pkg::CNR_MODE_SERIAL)
    |=> word_q.data == {7'h00, $past(ser_s2_q)}) // RQ6
    else $error("Serial bit mismatch");

  // Enable toward the PHY follows the request one cycle late
  a_enable_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rst_b |=> receive_enable == $past(port_enable && is_cell(mode))) // RQ4
    else $error("Receive enable not following request");

  // A stopped port hands nothing over
  a_refused_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !port_enable |=> !valid_q) // RQ4
    else $error("Word while port disabled");

  sequence s_cell_closed;
    is_cell(mode) && !receive_enable;
  endsequence

  a_cell_closed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_cell_closed |=> !valid_q) // RQ4
    else $error("Octet taken while enable low");

  sequence s_octet_edge;
    s_edge ##0 receive_enable ##0 is_cell(mode);
  endsequence

  a_octet_width: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_octet_edge |=> valid_q && word_q.width == cnr_pkg::CNR_WIDTH_OCTET) // RQ1
    else $error("Octet width code wrong");

  a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_octet_edge ##0 (octet_cnt_q != 6'(cnr_pkg::CNR_CELL_OCTETS - 1))
    |=> octet_cnt_q == $past(octet_cnt_q) + 6'h01) // RQ2
    else $error("Octet count did not step");

  a_count_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_octet_edge ##0 (octet_cnt_q == 6'(cnr_pkg::CNR_CELL_OCTETS - 1))
    |=> octet_cnt_q == cnr_pkg::CNR_CNT_RST) // RQ2
    else $error("Octet count did not wrap");

  a_start_marks: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_octet_edge ##0 (octet_cnt_q == cnr_pkg::CNR_CNT_RST)
    |=> word_q.cell_start) // RQ2
    else $error("Cell start not marked");

  // Counter held clear outside cell mode so a later cell starts aligned
  a_count_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !is_cell(mode) |=> octet_cnt_q == cnr_pkg::CNR_CNT_RST) // RQ2
    else $error("Octet count running outside cell mode");

  a_nibble_width: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_edge ##0 (mode == cnr_pkg::CNR_MODE_NIBBLE)
    |=> word_q.width == cnr_pkg::CNR_WIDTH_NIBBLE) // RQ5
    else $error("Nibble width code wrong");

  a_serial_width: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_edge ##0 (mode == cnr_pkg::CNR_MODE_SERIAL)
    |=> word_q.width == cnr_pkg::CNR_WIDTH_BIT) // RQ6
    else $error("Serial width code wrong");
endmodule
`default_nettype wire

/* File: cnr_phy_model.sv */
// Behavioural link-side PHY model
`timescale 1ns/100ps
`default_nettype none
module cnr_phy_model (
  // Control
  input wire logic drive,
  // Link pins
  output logic rx_clk,
  output var logic [7:0] rx_data,
  output logic rx_serial
);
  logic [7:0] last_q = 8'h00;
  initial rx_clk = 1'b0;
  initial rx_serial = 1'b0;
  // Released bus shows inverse, so a stale value never matches
  assign rx_data = drive ? last_q : ~last_q;
  // Units go back to back with no gaps, as idle cells would fill
  task automatic send(input logic [7:0] v, input logic b);
    last_q = v;
    rx_serial = b;
    #62 rx_clk = 1'b1;
    #63 rx_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: cnr_receive_port_tb.sv */
// Testbench for the cell and nibble receive port
`timescale 1ns/100ps
`default_nettype none
module cnr_receive_port_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  cnr_pkg::cnr_mode_t mode = cnr_pkg::CNR_MODE_CELL;
  logic port_enable = 1'b0;
  logic rx_clk, rx_serial, receive_enable, word_valid;
  logic [7:0] rx_data;
  cnr_pkg::cnr_word_t word;
  cnr_pkg::cnr_word_t got[$];
  int fail_count = 0;
  int tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    if (word_valid === 1'b1) got.push_back(word);
  end
  cnr_phy_model PHY (.drive(receive_enable | (mode != cnr_pkg::CNR_MODE_CELL)),
    .rx_clk(rx_clk), .rx_data(rx_data), .rx_serial(rx_serial));
  cnr_receive_port DUT (.sys_clk(sys_clk), .rst_b(rst_b), .mode(mode),
    .port_enable(port_enable), .rx_clk(rx_clk), .rx_data(rx_data),
    .rx_serial(rx_serial), .receive_enable(receive_enable), .word(word),
    .word_valid(word_valid));
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic setup(input cnr_pkg::cnr_mode_t m, input logic en);
    @(negedge sys_clk);
    mode = m;
    port_enable = en;
    repeat (4) @(negedge sys_clk);
    got.delete();
  endtask
  task automatic settle(input int n);
    repeat (8) @(negedge sys_clk);
    chk(13'(got.size()), 13'(n));
  endtask
  task automatic cell_run;
    setup(cnr_pkg::CNR_MODE_CELL, 1'b1);
    chk(13'(receive_enable), 13'h0001);
    for (int i = 0; i < 54; i++) PHY.send(8'(i * 37 + 3), 1'b0);
    settle(54);
    for (int i = 0; i < 54; i++)
      chk(got[i], {8'(i * 37 + 3), cnr_pkg::CNR_WIDTH_OCTET, i % 53 == 0,
        i == 52});
  endtask
  task automatic nibble_run;
    setup(cnr_pkg::CNR_MODE_NIBBLE, 1'b1);
    for (int i = 0; i < 16; i++) PHY.send({4'(~i), 4'(i)}, 1'b0);
    settle(16);
    for (int i = 0; i < 16; i++)
      chk({got[i].data, got[i].width},
        {4'h0, 4'(i), cnr_pkg::CNR_WIDTH_NIBBLE});
  endtask
  task automatic serial_run;
    setup(cnr_pkg::CNR_MODE_SERIAL, 1'b1);
    for (int i = 0; i < 4; i++) PHY.send(8'h00, ~i[0]);
    settle(4);
    for (int i = 0; i < 4; i++)
      chk({got[i].data, got[i].width},
        {7'h00, ~i[0], cnr_pkg::CNR_WIDTH_BIT});
  endtask
  task automatic off_run;
    setup(cnr_pkg::CNR_MODE_CELL, 1'b0);
    chk(13'(receive_enable), 13'h0000);
    for (int i = 0; i < 3; i++) PHY.send(8'h5A, 1'b1);
    settle(0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    cell_run();
    nibble_run();
    serial_run();
    off_run();
    complete_run();
  end
endmodule
`default_nettype wire
